// [hw/sbwoc_pkg.sv]
// Purpose: Shared constants and types for the management serial write block.
// Assumes: Byte-wide register bank indexed by an 8-bit index.
// Notes: Index values are the register byte numbers.
package sbwoc_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [7:0] IDX_LOOP_FREQ = 8'h00;
  localparam logic [7:0] IDX_OE_LOW = 8'h01;
  localparam logic [7:0] IDX_OE_MID = 8'h02;
  localparam logic [7:0] IDX_RSVD_FOUR = 8'h04;
  localparam logic [7:0] IDX_VENDOR_REV = 8'h05;
  localparam logic [7:0] IDX_RSVD_EIGHT = 8'h08;

  // ==========================================================================
  // Field layout of the loop mode / frequency select byte
  localparam int LOOP_MODE_HI = 7;
  localparam int LOOP_MODE_LO = 6;
  localparam int PAIR18_BIT = 5;
  localparam int PAIR16_BIT = 3;
  localparam int FREQ_BIT = 0;

  // Writable bits per byte and reset values
  localparam logic [7:0] LOOP_FREQ_WMASK = 8'h38;
  localparam logic [7:0] OE_LOW_WMASK = 8'hff;
  localparam logic [7:0] OE_MID_WMASK = 8'hf8;
  localparam logic [7:0] NO_WMASK = 8'h00;
  localparam logic [2:0] PAIR16_18_RESET = 3'h7;
  localparam logic [7:0] OE_LOW_RESET = 8'hff;
  localparam logic [4:0] OE_MID_RESET = 5'h1f;
  localparam int OE_MID_LO = 3;

  // ==========================================================================
  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic DIR_WRITE = 1'b0;
  localparam int ADDR_WIDTH = 7;
  localparam int STRAP_WIDTH = 4;
  localparam int NUM_PAIRS = 19;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    SBWOC_ST_ADDR = 3'b000,
    SBWOC_ST_INDEX = 3'b001,
    SBWOC_ST_COUNT = 3'b010,
    SBWOC_ST_DATA = 3'b011,
    SBWOC_ST_IGNORE = 3'b100
  } sbwoc_state_t;

  // One register write passed from the link domain to the bank
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } sbwoc_wr_t;

  // Straps caught at the first power-good rise
  typedef struct packed {
    logic [1:0] loop_mode;
    logic freq_sel;
    logic [STRAP_WIDTH-1:0] addr_sel;
  } sbwoc_strap_t;

endpackage

// [hw/sbwoc_sync.sv]
// Purpose: Two-flop level synchroniser.
// Assumes: Input bits are levels or change rarely relative to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps

module sbwoc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [hw/sbwoc_top.sv]
// Purpose: Slave side of the management serial port: indexed block writes into a
//          byte-wide bank that gates differential output pairs.
// Assumes: smb_clk is the serial bus clock line; sda is open drain.
// Notes: The link engine runs on smb_clk; the bank runs on clk.
`timescale 1ns/1ps

// Function
// - The device acknowledges the address, index, count and every data byte within the count one at a time.
// - The X data bytes land in indices N to N+X-1, the index advancing after each byte.
// - The device answers only the slave address set by its address-select straps.
// - Byte 0 bits 7 and 6 read back the latched loop mode, bit 7 the upper bit.
// - Byte 0 bit 0 reads back the latched frequency strap, 1 for 100 MHz, 0 for 133 MHz.
// - Byte 0 bits 5..3 enable pairs 18..16, reset to 1, 0 means high impedance.
// - Byte 1 bits 7..0 enable pairs 7..0 with the same coding, reset to 1.
// - Byte 2 bits 7..3 enable pairs 15..11 with the same coding, reset to 1.
// - Bytes 4 and 8 and byte 0 bits 2 and 1 are reserved with no function.
// - Byte 5 is a read-only vendor and revision code, revision in the upper bits.
// - Frequency and address straps are caught at the first power-good rise and held.
module sbwoc_top #(
  parameter logic [2:0] ADDR_BASE = 3'h6,
  parameter logic [7:0] VENDOR_REV_ID = 8'h5a,
  parameter logic UNGATED_PAIR_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic smb_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic power_good_in,
  input wire logic freq_strap_in,
  input wire logic [1:0] loop_mode_in,
  input wire logic [sbwoc_pkg::STRAP_WIDTH-1:0] slave_addr_strap,
  input wire logic [7:0] view_idx,
  output logic [7:0] view_data,
  output logic [sbwoc_pkg::NUM_PAIRS-1:0] out_pair_gate,
  output logic straps_latched
);

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] wr_mask(input logic [7:0] idx);
    case (idx)
      sbwoc_pkg::IDX_LOOP_FREQ: wr_mask = sbwoc_pkg::LOOP_FREQ_WMASK;
      sbwoc_pkg::IDX_OE_LOW: wr_mask = sbwoc_pkg::OE_LOW_WMASK;
      sbwoc_pkg::IDX_OE_MID: wr_mask = sbwoc_pkg::OE_MID_WMASK;
      default: wr_mask = sbwoc_pkg::NO_WMASK;
    endcase
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ==========================================================================
  // Pin synchronisers into the clk domain
  logic scl_s;
  logic sda_s;
  logic pg_s;
  sbwoc_pkg::sbwoc_strap_t strap_s;
  sbwoc_pkg::sbwoc_strap_t strap_raw;

  assign strap_raw = '{loop_mode: loop_mode_in, freq_sel: freq_strap_in,
                       addr_sel: slave_addr_strap};

  sbwoc_sync #(.WIDTH(3)) u_sync_pins (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({smb_clk, sda_i, power_good_in}),
    .sync_out({scl_s, sda_s, pg_s})
  );

  sbwoc_sync #(.WIDTH($bits(sbwoc_pkg::sbwoc_strap_t))) u_sync_straps (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(strap_raw),
    .sync_out(strap_s)
  );

  // ==========================================================================
  // Strap capture at the first power-good rise; later falls are power-down only
  logic pg_d_q;
  logic latched_q;
  sbwoc_pkg::sbwoc_strap_t strap_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_d_q <= 1'b0;
      latched_q <= 1'b0;
      strap_q <= '0;
    end else begin
      pg_d_q <= pg_s;
      if (pg_s && !pg_d_q && !latched_q) begin
        latched_q <= 1'b1;
        strap_q <= strap_s;
      end
    end
  end

  assign straps_latched = latched_q;

  // ==========================================================================
  // Start / stop detection; holds the link engine in reset between frames
  logic sda_d_q;
  logic in_frame_q;
  logic frame_rst_q;
  logic start_ev;
  logic stop_ev;

  assign start_ev = scl_s && sda_d_q && !sda_s;
  assign stop_ev = scl_s && !sda_d_q && sda_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_d_q <= 1'b1;
      in_frame_q <= 1'b0;
      frame_rst_q <= 1'b1;
    end else begin
      sda_d_q <= sda_s;
      if (start_ev) begin
        in_frame_q <= 1'b1;
        frame_rst_q <= 1'b1;
      end else if (stop_ev) begin
        in_frame_q <= 1'b0;
        frame_rst_q <= 1'b1;
      end else if (in_frame_q && !scl_s) begin
        // Released while the clock line is low, so the first rising edge is clean
        frame_rst_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Link domain: bit engine on smb_clk
  logic eng_rst_n;
  logic [sbwoc_pkg::ADDR_WIDTH-1:0] my_addr;
  logic [sbwoc_pkg::ADDR_WIDTH-1:0] my_addr_l;
  logic addr_ok_l;

  assign eng_rst_n = rst_n && !frame_rst_q;
  assign my_addr = {ADDR_BASE, strap_q.addr_sel};

  // Quasi-static after power-good; resynchronised for the link side
  sbwoc_sync #(.WIDTH(sbwoc_pkg::ADDR_WIDTH + 1)) u_sync_addr (
    .clk(smb_clk),
    .rst_n(rst_n),
    .async_in({latched_q, my_addr}),
    .sync_out({addr_ok_l, my_addr_l})
  );

  logic [3:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic ack_q;
  logic ack_drive_q;
  sbwoc_pkg::sbwoc_state_t state_q;
  logic [7:0] idx_q;
  logic [7:0] left_q;

  assign rx_byte = {shift_q, sda_i};
  assign byte_done = (bit_cnt_q == sbwoc_pkg::BITS_PER_BYTE - 4'h1);

  always_ff @(posedge smb_clk or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      bit_cnt_q <= sbwoc_pkg::BIT_ZERO;
      shift_q <= '0;
    end else if (bit_cnt_q == sbwoc_pkg::BITS_PER_BYTE) begin
      bit_cnt_q <= sbwoc_pkg::BIT_ZERO; // acknowledge slot passes
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q <= rx_byte[6:0];
    end
  end

  // Byte-level sequence: address, index, count, then data bytes
  always_ff @(posedge smb_clk or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      state_q <= sbwoc_pkg::SBWOC_ST_ADDR;
      idx_q <= '0;
      left_q <= '0;
      ack_q <= 1'b0;
    end else if (byte_done) begin
      case (state_q)
        sbwoc_pkg::SBWOC_ST_ADDR: begin
          if (addr_ok_l && rx_byte[7:1] == my_addr_l && rx_byte[0] == sbwoc_pkg::DIR_WRITE) begin
            ack_q <= 1'b1;
            state_q <= sbwoc_pkg::SBWOC_ST_INDEX;
          end else begin
            ack_q <= 1'b0;
            state_q <= sbwoc_pkg::SBWOC_ST_IGNORE;
          end
        end
        sbwoc_pkg::SBWOC_ST_INDEX: begin
          idx_q <= rx_byte;
          ack_q <= 1'b1;
          state_q <= sbwoc_pkg::SBWOC_ST_COUNT;
        end
        sbwoc_pkg::SBWOC_ST_COUNT: begin
          left_q <= rx_byte;
          ack_q <= 1'b1;
          state_q <= sbwoc_pkg::SBWOC_ST_DATA;
        end
        sbwoc_pkg::SBWOC_ST_DATA: begin
          if (left_q != sbwoc_pkg::BYTE_ZERO) begin
            ack_q <= 1'b1;
            idx_q <= idx_q + sbwoc_pkg::BYTE_ONE;
            left_q <= left_q - sbwoc_pkg::BYTE_ONE;
          end else begin
            // Bytes beyond the stated count are refused
            ack_q <= 1'b0;
            state_q <= sbwoc_pkg::SBWOC_ST_IGNORE;
          end
        end
        sbwoc_pkg::SBWOC_ST_IGNORE: begin
          ack_q <= 1'b0;
        end
        default: begin
          ack_q <= 1'b0;
          state_q <= sbwoc_pkg::SBWOC_ST_IGNORE;
        end
      endcase
    end
  end

  // Acknowledge is driven from the falling edge so sda is steady before the rising edge
  always_ff @(negedge smb_clk or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      ack_drive_q <= 1'b0;
    end else begin
      ack_drive_q <= ack_q && (bit_cnt_q == sbwoc_pkg::BITS_PER_BYTE);
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = ack_drive_q;

  // ==========================================================================
  // Write word handed to clk by a toggle; the word holds for a whole byte time,
  // far longer than the two-flop delay, so it is stable when sampled
  sbwoc_pkg::sbwoc_wr_t wr_word_q;
  logic wr_tgl_q;

  always_ff @(posedge smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_word_q <= '0;
      wr_tgl_q <= 1'b0;
    end else if (eng_rst_n && byte_done && state_q == sbwoc_pkg::SBWOC_ST_DATA &&
                 left_q != sbwoc_pkg::BYTE_ZERO) begin
      wr_word_q <= '{idx: idx_q, data: rx_byte};
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  logic wr_tgl_s;
  logic wr_tgl_d_q;
  logic wr_ev;

  sbwoc_sync #(.WIDTH(1)) u_sync_wr (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(wr_tgl_q),
    .sync_out(wr_tgl_s)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl_d_q <= 1'b0;
    end else begin
      wr_tgl_d_q <= wr_tgl_s;
    end
  end

  assign wr_ev = wr_tgl_s ^ wr_tgl_d_q;

  // ==========================================================================
  // Register bank in the clk domain
  logic [7:0] loop_freq_q;
  logic [7:0] oe_low_q;
  logic [7:0] oe_mid_q;
  logic [7:0] wr_data;
  logic [7:0] wr_idx;

  assign wr_idx = wr_word_q.idx;
  assign wr_data = wr_word_q.data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_freq_q <= {2'h0, sbwoc_pkg::PAIR16_18_RESET, 3'h0};
      oe_low_q <= sbwoc_pkg::OE_LOW_RESET;
      oe_mid_q <= {sbwoc_pkg::OE_MID_RESET, 3'h0};
    end else if (wr_ev) begin
      // Masks keep read-only and reserved bits untouched
      case (wr_idx)
        sbwoc_pkg::IDX_LOOP_FREQ:
          loop_freq_q <= merge(loop_freq_q, wr_data, wr_mask(wr_idx));
        sbwoc_pkg::IDX_OE_LOW:
          oe_low_q <= merge(oe_low_q, wr_data, wr_mask(wr_idx));
        sbwoc_pkg::IDX_OE_MID:
          oe_mid_q <= merge(oe_mid_q, wr_data, wr_mask(wr_idx));
        default: begin
          // Reserved, read-only and absent bytes ignore data
        end
      endcase
    end
  end

  // Byte 0 as seen by software: latched straps in the read-only fields
  logic [7:0] byte0_view;

  always_comb begin
    byte0_view = loop_freq_q & sbwoc_pkg::LOOP_FREQ_WMASK;
    byte0_view[sbwoc_pkg::LOOP_MODE_HI] = strap_q.loop_mode[1];
    byte0_view[sbwoc_pkg::LOOP_MODE_LO] = strap_q.loop_mode[0];
    byte0_view[sbwoc_pkg::FREQ_BIT] = strap_q.freq_sel;
  end

  // Local readback port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      view_data <= '0;
    end else begin
      case (view_idx)
        sbwoc_pkg::IDX_LOOP_FREQ: view_data <= byte0_view;
        sbwoc_pkg::IDX_OE_LOW: view_data <= oe_low_q;
        sbwoc_pkg::IDX_OE_MID: view_data <= oe_mid_q & sbwoc_pkg::OE_MID_WMASK;
        sbwoc_pkg::IDX_VENDOR_REV: view_data <= VENDOR_REV_ID;
        sbwoc_pkg::IDX_RSVD_FOUR: view_data <= '0;
        sbwoc_pkg::IDX_RSVD_EIGHT: view_data <= '0;
        default: view_data <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Output pair gates; pairs with no control bit stay enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_pair_gate <= '1;
    end else begin
      out_pair_gate[7:0] <= oe_low_q;
      out_pair_gate[10:8] <= {3{UNGATED_PAIR_EN}};
      out_pair_gate[15:11] <= oe_mid_q[7:sbwoc_pkg::OE_MID_LO];
      out_pair_gate[18:16] <=
        loop_freq_q[sbwoc_pkg::PAIR18_BIT:sbwoc_pkg::PAIR16_BIT];
    end
  end

endmodule

// [verification/sbwoc_chk.sv]
// Purpose: Port-level checks of the management serial write block.
// Assumes: Straps are held steady around the first power-good rise.
// Notes: Bound into sbwoc_top.
`timescale 1ns/1ps
module sbwoc_chk #(
  parameter logic [7:0] VENDOR_REV_ID = 8'h5a
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic smb_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic power_good_in,
  input wire logic freq_strap_in,
  input wire logic [1:0] loop_mode_in,
  input wire logic [7:0] view_idx,
  input wire logic [7:0] view_data,
  input wire logic [sbwoc_pkg::NUM_PAIRS-1:0] out_pair_gate,
  input wire logic straps_latched
);
  // ==========================================
  // Strap capture at the raw power-good rise
  logic pg_q;
  logic got_q;
  logic [2:0] cap_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= 1'b0;
      got_q <= 1'b0;
      cap_q <= 3'h0;
    end else begin
      pg_q <= power_good_in;
      if (power_good_in && !pg_q && !got_q) begin
        got_q <= 1'b1;
        cap_q <= {loop_mode_in, freq_strap_in};
      end
    end
  end

  // ==========================================
  // Properties
  property p_ack_one_bit;
    @(posedge smb_clk) disable iff (!rst_n) sda_oe |=> !sda_oe;
  endproperty
  a_ack_one_bit: assert property (p_ack_one_bit)
    else $error("ack held past one bit");
  property p_sda_low;
    @(posedge clk) disable iff (!rst_n) sda_oe |-> sda_o == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data line driven high");
  property p_no_ack_unlatched;
    @(posedge clk) disable iff (!rst_n) !straps_latched |-> !sda_oe;
  endproperty
  a_no_ack_unlatched: assert property (p_no_ack_unlatched)
    else $error("ack before straps latched");
  property p_latch_sticky;
    @(posedge clk) disable iff (!rst_n) straps_latched |=> straps_latched;
  endproperty
  a_latch_sticky: assert property (p_latch_sticky)
    else $error("latch flag dropped");
  property p_latch_after_pg;
    @(posedge clk) disable iff (!rst_n) $rose(straps_latched) |-> got_q;
  endproperty
  a_latch_after_pg: assert property (p_latch_after_pg)
    else $error("latch without power good rise");
  property p_strap_readback;
    @(posedge clk) disable iff (!rst_n)
      straps_latched && got_q && view_idx == 8'h00 |=>
      view_data[7:6] == cap_q[2:1] && view_data[0] == cap_q[0];
  endproperty
  a_strap_readback: assert property (p_strap_readback)
    else $error("strap readback wrong");
  property p_rsvd_bits;
    @(posedge clk) disable iff (!rst_n) view_idx == 8'h00 |=> view_data[2:1] == 2'b00;
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits)
    else $error("reserved bits nonzero");
  property p_rsvd_bytes;
    @(posedge clk) disable iff (!rst_n)
      view_idx == 8'h04 || view_idx == 8'h08 |=> view_data == 8'h00;
  endproperty
  a_rsvd_bytes: assert property (p_rsvd_bytes)
    else $error("reserved byte nonzero");
  property p_vendor;
    @(posedge clk) disable iff (!rst_n) view_idx == 8'h05 |=> view_data == VENDOR_REV_ID;
  endproperty
  a_vendor: assert property (p_vendor)
    else $error("identification byte wrong");
  property p_gate_reset;
    @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> &out_pair_gate;
  endproperty
  a_gate_reset: assert property (p_gate_reset)
    else $error("gates not enabled at reset");
endmodule

bind sbwoc_top sbwoc_chk #(.VENDOR_REV_ID(VENDOR_REV_ID)) chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .smb_clk(smb_clk),
  .sda_o(sda_o),
  .sda_oe(sda_oe),
  .power_good_in(power_good_in),
  .freq_strap_in(freq_strap_in),
  .loop_mode_in(loop_mode_in),
  .view_idx(view_idx),
  .view_data(view_data),
  .out_pair_gate(out_pair_gate),
  .straps_latched(straps_latched)
);

// [verification/sbwoc_host_model.sv]
// Purpose: Management bus host that issues indexed block writes.
// Assumes: Data line has a pull-up; the clock idles high between frames.
// Notes: Slow mode stretches the clock low phase after each data bit, not after ack slots.
`timescale 1ns/1ps
module sbwoc_host_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================
  // One frame: start, bytes with ack slots, stop
  // Data moves just after the clock falls and rises more than one bank clock
  // period before the clock does, so the synchronised view never sees the
  // data and a rising clock change together and takes them for a start or stop
  task automatic frame(input logic [7:0] b [16], input int nb, input bit slow,
      output logic [15:0] acks);
    acks = 16'h0000;
    #200;
    sda_pull = 1'b1;
    #200;
    scl = 1'b0;
    // Long first low lets the engine leave its start reset
    #200;
    for (int k = 0; k < nb; k++) begin
      for (int i = 7; i >= 0; i--) begin
        #5;
        sda_pull = ~b[k][i];
        #35;
        scl = 1'b1;
        #40;
        scl = 1'b0;
        if (slow) #120;
      end
      #5;
      sda_pull = 1'b0;
      #35;
      scl = 1'b1;
      acks[k] = ~sda_wire;
      #40;
      scl = 1'b0;
    end
    #5;
    sda_pull = 1'b1;
    #35;
    scl = 1'b1;
    #200;
    sda_pull = 1'b0;
    #200;
  endtask
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the serial write block.
// Assumes: Host model drives the link; bench drives straps and readback.
// Notes: A shadow bank predicts every readable byte and gate.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] VID = 8'h3c; // Arbitrary identification value
  logic clk;
  logic rst_n;
  logic smb_clk;
  logic sda_pull;
  logic sda_i;
  logic sda_o;
  logic sda_oe;
  logic power_good_in;
  logic freq_strap_in;
  logic [1:0] loop_mode_in;
  logic [sbwoc_pkg::STRAP_WIDTH-1:0] slave_addr_strap;
  logic [7:0] view_idx;
  logic [7:0] view_data;
  logic [sbwoc_pkg::NUM_PAIRS-1:0] out_pair_gate;
  logic straps_latched;
  logic [7:0] shadow [0:8];
  logic [6:0] dev_addr;
  int miscompares;
  int check_count;

  // Pull-up resolves the wired-AND data line
  assign sda_i = ~(sda_pull | (sda_oe & ~sda_o));

  sbwoc_host_model host_u (.scl(smb_clk), .sda_pull(sda_pull), .sda_wire(sda_i));
  sbwoc_top #(.VENDOR_REV_ID(VID)) dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .smb_clk(smb_clk),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .power_good_in(power_good_in),
    .freq_strap_in(freq_strap_in),
    .loop_mode_in(loop_mode_in),
    .slave_addr_strap(slave_addr_strap),
    .view_idx(view_idx),
    .view_data(view_data),
    .out_pair_gate(out_pair_gate),
    .straps_latched(straps_latched)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================
  // Checking and prediction
  task automatic fail(input string m, input logic [18:0] g, input logic [18:0] e);
    miscompares++;
    $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) fail(m, 19'(g), 19'(e));
  endtask
  task automatic cmp_gate(input logic [18:0] g, input logic [18:0] e, input string m);
    check_count++;
    if (g !== e) fail(m, g, e);
  endtask
  task automatic cmp_ack(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e) fail(m, 19'(g), 19'(e));
  endtask
  function automatic logic [7:0] wmask(input logic [7:0] idx);
    case (idx)
      8'h00: return 8'h38;
      8'h01: return 8'hff;
      8'h02: return 8'hf8;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [18:0] exp_gate();
    return {shadow[0][5:3], shadow[2][7:3], 3'b111, shadow[1]};
  endfunction
  task automatic check_regs(input string m);
    logic [7:0] idxs [6];
    idxs = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08};
    foreach (idxs[i]) begin
      @(posedge clk);
      view_idx <= idxs[i];
      repeat (2) @(posedge clk);
      #1;
      cmp_byte(view_data, shadow[idxs[i]], m);
    end
    cmp_gate(out_pair_gate, exp_gate(), m);
  endtask
  task automatic do_frame(input logic [6:0] a, input logic rw, input logic [7:0] n,
      input logic [7:0] x, input int nd, input bit slow, input string m);
    logic [7:0] b [16];
    logic [15:0] acks;
    logic [15:0] exp;
    logic [7:0] idx;
    b[0] = {a, rw};
    b[1] = n;
    b[2] = x;
    exp = 16'h0000;
    for (int k = 3; k < 3 + nd; k++) b[k] = 8'($urandom);
    // Random phase so link edges land anywhere within a bank clock period
    #($urandom_range(1, 24));
    host_u.frame(b, 3 + nd, slow, acks);
    for (int k = 0; k < 3 + nd; k++) begin
      exp[k] = (a == dev_addr) && (rw == sbwoc_pkg::DIR_WRITE) && (k < 3 || k - 3 < x);
      idx = n + 8'(k - 3);
      if (exp[k] && k >= 3 && idx <= 8'h08) begin
        shadow[idx] = (shadow[idx] & ~wmask(idx)) | (b[k] & wmask(idx));
      end
    end
    cmp_ack(acks, exp, m);
    check_regs(m);
    $display("Test done: %s", m);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] rn;
    void'($urandom(60));
    rst_n = 1'b0;
    power_good_in = 1'b0;
    freq_strap_in = 1'b0;
    loop_mode_in = 2'h0;
    slave_addr_strap = 4'h0;
    view_idx = 8'h00;
    miscompares = 0;
    check_count = 0;
    for (int i = 0; i < 9; i++) shadow[i] = 8'h00;
    shadow[1] = 8'hff;
    shadow[2] = 8'hf8;
    shadow[5] = VID;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp_gate(out_pair_gate, 19'h7ffff, "reset gates");
    cmp_byte({7'h00, straps_latched}, 8'h00, "reset latch");
    @(posedge clk);
    freq_strap_in <= 1'($urandom);
    loop_mode_in <= 2'($urandom);
    slave_addr_strap <= 4'($urandom);
    repeat (3) @(posedge clk);
    power_good_in <= 1'b1;
    for (int i = 0; i < 20 && straps_latched !== 1'b1; i++) @(posedge clk);
    dev_addr = {3'h6, slave_addr_strap};
    shadow[0] = {loop_mode_in, 3'b111, 2'b00, freq_strap_in};
    // Later strap moves and power-good pulses must not disturb the latch
    freq_strap_in <= ~freq_strap_in;
    loop_mode_in <= ~loop_mode_in;
    slave_addr_strap <= ~slave_addr_strap;
    power_good_in <= 1'b0;
    repeat (5) @(posedge clk);
    power_good_in <= 1'b1;
    repeat (5) @(posedge clk);
    cmp_byte({7'h00, straps_latched}, 8'h01, "latched");
    check_regs("straps");
    $display("Test done: straps");
    do_frame(dev_addr ^ 7'h01, 1'b0, 8'h01, 8'h01, 1, 0, "wrong address");
    do_frame(dev_addr, 1'b1, 8'h01, 8'h01, 1, 0, "read bit");
    do_frame(dev_addr, 1'b0, 8'h00, 8'h03, 3, 0, "bytes 0 to 2");
    do_frame(dev_addr, 1'b0, 8'h04, 8'h02, 2, 0, "fixed bytes");
    do_frame(dev_addr, 1'b0, 8'h08, 8'h01, 1, 1, "slow reserved");
    do_frame(dev_addr, 1'b0, 8'h01, 8'h00, 1, 0, "zero count");
    do_frame(dev_addr, 1'b0, 8'h01, 8'h01, 2, 0, "past count");
    for (int i = 0; i < 8; i++) begin
      rn = 8'($urandom_range(0, 2));
      do_frame(dev_addr, 1'b0, rn, 8'(3 - rn), 3 - int'(rn), 1'($urandom), "random");
    end
    stop_test();
  end
endmodule
